// file: logic/fclg_gate.sv
// Purpose: Command launch gate: parameter array, complete flag, permission check
// Assumes: Mode and security pins asynchronous; register port on clock
// Notes: Memory controller seen through launch and finish handshake
//
// Notes on behaviour
// - Erase-verify codes 0x01 and 0x02 accepted in every mode and security state.
// - Array commands 0x03..0x12 other than 0x05 and 0x0F (always refused) and 0x08, 0x0B, 0x0C, 0x0E (below) accepted except when secured in special mode.
// - Erase-all 0x08 and unsecure 0x0B accepted only in special mode.
// - Backdoor key verify 0x0C accepted only in normal mode.
// - Field margin 0x0E accepted only unsecured in special mode.
// - Special mode input high means special single-chip, else normal.
// - Secured input high means secured memory, else unsecured.
// - Erase-verify-all command checks every array and EEPROM block erased.
// - Index field selects the parameter word read or written.
// - Writing one to complete flag clears it and hands over parameters.
// - Complete flag stays zero while the command runs.
// - At finish flag returns to one and results land in the array.
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "fclg_defs.svh"
module fclg_gate
#(
   parameter int WORDS = 6
)
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic [7:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [15:0] rdata,
   input  wire logic        special_mode_input,
   input  wire logic        secured_state_input,
   output logic             cmd_launch,
   output logic      [7:0]  cmd_code_out,
   output logic             cmd_erase_verify_all,
   output logic      [15:0] cmd_word,
   output logic      [2:0]  cmd_word_idx,
   input  wire logic        cmd_finish,
   input  wire logic        res_we,
   input  wire logic [2:0]  res_idx,
   input  wire logic [15:0] res_data,
   output logic             irq
);
   initial
   begin
      if (WORDS < 1 || WORDS > 8)
         $error("WORDS must be 1 to 8");
   end

   typedef struct packed {
      logic [1:0]            spec_sync;
      logic [1:0]            sec_sync;
      logic [2:0]            idx;
      logic [WORDS-1:0][15:0] arr;
      logic [`FCLG_STAT_W-1:0] stat;
      logic [`FCLG_STAT_W-1:0] mask;
      fclg_pkg::fclg_state_t  state;
      logic [2:0]            xfer;
      logic                  launch;
      logic [7:0]            code;
      logic                  eva;
      logic [15:0]           word;
      logic [2:0]            widx;
      logic [15:0]           rdata;
      logic                  irq;
   } fclg_regs_t;

   fclg_regs_t cur_ff;
   fclg_regs_t nxt_ff;
   logic       permit;
   logic       special;
   logic       secured;
   logic       launch_req;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   assign special = cur_ff.spec_sync[1];
   assign secured = cur_ff.sec_sync[1];
   assign launch_req = wr && hit(addr, `FCLG_OFS_STATUS) && wdata[`FCLG_STAT_CCF];

   fclg_permit u_permit
   (
      .code    (cur_ff.arr[0][`FCLG_CODE_MSB:`FCLG_CODE_LSB]),
      .special (special),
      .secured (secured),
      .permit  (permit)
   );

   always_comb
   begin
      nxt_ff = cur_ff;
      nxt_ff.spec_sync = {cur_ff.spec_sync[0], special_mode_input};
      nxt_ff.sec_sync = {cur_ff.sec_sync[0], secured_state_input};
      nxt_ff.launch = 1'b0;
      nxt_ff.rdata = 16'h0000;
      if (wr && hit(addr, `FCLG_OFS_INDEX))
         nxt_ff.idx = wdata[2:0];
      if (wr && hit(addr, `FCLG_OFS_PARAM) && cur_ff.stat[`FCLG_STAT_CCF]
          && 32'(cur_ff.idx) < WORDS)
         nxt_ff.arr[cur_ff.idx] = wdata;
      if (wr && hit(addr, `FCLG_OFS_IRQ_MASK))
         nxt_ff.mask = wdata[`FCLG_STAT_W-1:0];
      if (wr && hit(addr, `FCLG_OFS_STATUS))
      begin
         nxt_ff.stat[`FCLG_STAT_ACCERR] = cur_ff.stat[`FCLG_STAT_ACCERR]
                                          & ~wdata[`FCLG_STAT_ACCERR];
         nxt_ff.stat[`FCLG_STAT_DONE] = cur_ff.stat[`FCLG_STAT_DONE]
                                        & ~wdata[`FCLG_STAT_DONE];
      end
      if (rd)
      begin
         if (hit(addr, `FCLG_OFS_INDEX))
            nxt_ff.rdata = {13'h0000, cur_ff.idx};
         else if (hit(addr, `FCLG_OFS_PARAM) && 32'(cur_ff.idx) < WORDS)
            nxt_ff.rdata = cur_ff.arr[cur_ff.idx];
         else if (hit(addr, `FCLG_OFS_STATUS))
            nxt_ff.rdata = {13'h0000, cur_ff.stat};
         else if (hit(addr, `FCLG_OFS_IRQ_MASK))
            nxt_ff.rdata = {13'h0000, cur_ff.mask};
         else if (hit(addr, `FCLG_OFS_MODE))
            nxt_ff.rdata = {14'h0000, secured, special};
      end
      unique case (cur_ff.state)
         fclg_pkg::FCLG_IDLE:
         begin
            if (launch_req && cur_ff.stat[`FCLG_STAT_CCF])
            begin
               if (permit)
               begin
                  nxt_ff.stat[`FCLG_STAT_CCF] = 1'b0;
                  nxt_ff.state = fclg_pkg::FCLG_RUN;
                  nxt_ff.xfer = 3'h0;
                  nxt_ff.code = cur_ff.arr[0][`FCLG_CODE_MSB:`FCLG_CODE_LSB];
                  nxt_ff.eva = (cur_ff.arr[0][`FCLG_CODE_MSB:`FCLG_CODE_LSB]
                                == 8'h01);
                  nxt_ff.launch = 1'b1;
                  nxt_ff.word = cur_ff.arr[0];
                  nxt_ff.widx = 3'h0;
               end
               else
                  nxt_ff.stat[`FCLG_STAT_ACCERR] = 1'b1;
            end
         end
         fclg_pkg::FCLG_RUN:
         begin
            if (32'(cur_ff.xfer) + 1 < WORDS)
            begin
               nxt_ff.xfer = cur_ff.xfer + 3'h1;
               nxt_ff.word = cur_ff.arr[cur_ff.xfer + 3'h1];
               nxt_ff.widx = cur_ff.xfer + 3'h1;
            end
            if (res_we && 32'(res_idx) < WORDS)
               nxt_ff.arr[res_idx] = res_data;
            if (cmd_finish)
               nxt_ff.state = fclg_pkg::FCLG_DONE;
         end
         fclg_pkg::FCLG_DONE:
         begin
            nxt_ff.stat[`FCLG_STAT_CCF] = 1'b1;
            nxt_ff.stat[`FCLG_STAT_DONE] = 1'b1;
            nxt_ff.state = fclg_pkg::FCLG_IDLE;
         end
      endcase
      nxt_ff.irq = |(nxt_ff.stat[`FCLG_STAT_W-1:1] & nxt_ff.mask[`FCLG_STAT_W-1:1]);
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cur_ff <= '0;
         cur_ff.stat <= 3'h1;
         cur_ff.idx <= `FCLG_IDX_RESET;
         cur_ff.mask <= `FCLG_MASK_RESET;
         cur_ff.state <= fclg_pkg::FCLG_IDLE;
      end
      else
         cur_ff <= nxt_ff;
   end

   assign rdata = cur_ff.rdata;
   assign cmd_launch = cur_ff.launch;
   assign cmd_code_out = cur_ff.code;
   assign cmd_erase_verify_all = cur_ff.eva;
   assign cmd_word = cur_ff.word;
   assign cmd_word_idx = cur_ff.widx;
   assign irq = cur_ff.irq;

   a_flag_low_run: assert property (@(posedge clock) disable iff (!rst_n)
      cur_ff.state == fclg_pkg::FCLG_RUN |-> !cur_ff.stat[`FCLG_STAT_CCF])
      else $error("Complete flag high while running");
   a_launch_clears: assert property (@(posedge clock) disable iff (!rst_n)
      cmd_launch |-> !cur_ff.stat[`FCLG_STAT_CCF] && $past(permit))
      else $error("Launch without clear or permit");
   a_refused_err: assert property (@(posedge clock) disable iff (!rst_n)
      launch_req && cur_ff.stat[`FCLG_STAT_CCF] && !permit
      |=> cur_ff.stat[`FCLG_STAT_ACCERR] && !cmd_launch)
      else $error("Refused code did not flag error");
   a_finish_sets: assert property (@(posedge clock) disable iff (!rst_n)
      cur_ff.state == fclg_pkg::FCLG_RUN && cmd_finish
      |=> ##1 cur_ff.stat[`FCLG_STAT_CCF])
      else $error("Flag not set after finish");
   a_busy_nolaunch: assert property (@(posedge clock) disable iff (!rst_n)
      !cur_ff.stat[`FCLG_STAT_CCF] |=> !cmd_launch)
      else $error("Launch while busy");
   a_eva_code: assert property (@(posedge clock) disable iff (!rst_n)
      cmd_launch |-> cmd_erase_verify_all == (cmd_code_out == 8'h01))
      else $error("Erase verify all flag wrong");
   a_verify_always: assert property (@(posedge clock) disable iff (!rst_n)
      cur_ff.arr[0][15:8] == 8'h02 |-> permit)
      else $error("Erase verify block refused");
   a_secure_special: assert property (@(posedge clock) disable iff (!rst_n)
      special && secured && cur_ff.arr[0][15:8] == 8'h06 |-> !permit)
      else $error("Program allowed when secured special");
   a_unsec_normal: assert property (@(posedge clock) disable iff (!rst_n)
      !special && cur_ff.arr[0][15:8] == 8'h0B |-> !permit)
      else $error("Unsecure allowed in normal mode");
   a_key_special: assert property (@(posedge clock) disable iff (!rst_n)
      special && cur_ff.arr[0][15:8] == 8'h0C |-> !permit)
      else $error("Key verify allowed in special mode");
   a_field_margin: assert property (@(posedge clock) disable iff (!rst_n)
      cur_ff.arr[0][15:8] == 8'h0E |-> permit == (special && !secured))
      else $error("Field margin permission wrong");

   c_launch: cover property (@(posedge clock) disable iff (!rst_n) cmd_launch);
   c_refuse: cover property (@(posedge clock) disable iff (!rst_n)
      launch_req && !permit && cur_ff.stat[`FCLG_STAT_CCF]);
   c_complete: cover property (@(posedge clock) disable iff (!rst_n)
      cur_ff.state == fclg_pkg::FCLG_DONE);
   c_result: cover property (@(posedge clock) disable iff (!rst_n)
      cur_ff.state == fclg_pkg::FCLG_RUN && res_we);
endmodule
`default_nettype wire

// file: common/fclg_defs.svh
// Purpose: Offsets, field positions, reset values and counts of the launch gate
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef FCLG_DEFS_SVH
`define FCLG_DEFS_SVH
`define FCLG_OFS_INDEX     8'h00
`define FCLG_OFS_PARAM     8'h04
`define FCLG_OFS_STATUS    8'h08
`define FCLG_OFS_IRQ_MASK  8'h0C
`define FCLG_OFS_MODE      8'h10
`define FCLG_STAT_CCF      0
`define FCLG_STAT_ACCERR   1
`define FCLG_STAT_DONE     2
`define FCLG_STAT_W        3
`define FCLG_MODE_SPECIAL  0
`define FCLG_MODE_SECURED  1
`define FCLG_CODE_MSB      15
`define FCLG_CODE_LSB      8
`define FCLG_EXEC_CYCLES   16
`define FCLG_IDX_RESET     3'h0
`define FCLG_MASK_RESET    3'h0
`endif

// file: common/fclg_pkg.sv
// Purpose: Types of the flash command launch gate
// Assumes: Nothing
// Notes: Constants live in fclg_defs.svh
package fclg_pkg;
   typedef enum logic [1:0] {
      FCLG_IDLE,
      FCLG_RUN,
      FCLG_DONE
   } fclg_state_t;
endpackage

// file: logic/fclg_permit.sv
// Purpose: Decides whether a command code may run in the current mode and security state
// Assumes: Mode and security inputs already synchronised
// Notes: Purely combinational
`timescale 1ns/10ps
`default_nettype none
module fclg_permit
(
   input  wire logic [7:0] code,
   input  wire logic       special,
   input  wire logic       secured,
   output logic            permit
);
   always_comb
   begin
      unique case (code)
         8'h01, 8'h02:
            permit = 1'b1;
         8'h03, 8'h04, 8'h06, 8'h07, 8'h09, 8'h0A, 8'h0D, 8'h10, 8'h11, 8'h12:
            permit = !(special && secured);
         8'h08, 8'h0B:
            permit = special;
         8'h0C:
            permit = !special;
         8'h0E:
            permit = special && !secured;
         default:
            permit = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// file: verification/tb_flash_command_launch_gate.sv
// Purpose: Self-checking bench of the command launch gate
// Assumes: Mode inputs settle within four cycles
// Notes: Rows hold a code and a permit mask, one bit per mode
`timescale 1ns/10ps
`default_nettype none
`include "fclg_defs.svh"
module tb_flash_command_launch_gate;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        sp = 1'b0;
   logic        se = 1'b0;
   logic        fin = 1'b0;
   logic        res_we = 1'b0;
   logic [2:0]  res_idx = 3'h0;
   logic [7:0]  addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] res_data = 16'h0000;
   logic [15:0] rdata;
   logic [15:0] cmd_word;
   logic [7:0]  cmd_code_out;
   logic        cmd_launch;
   logic        evall;
   logic        irq;
   logic        seen;
   logic [15:0] word0;
   int          failures = 0;
   int          n_tests = 0;
   logic [11:0] rows [19] = '{12'h01F, 12'h02F, 12'h037, 12'h047, 12'h050, 12'h067, 12'h077,
      12'h08A, 12'h097, 12'h0A7, 12'h0BA, 12'h0C5, 12'h0D7, 12'h0E2, 12'h0F0, 12'h107,
      12'h117, 12'h127, 12'h130};

   fclg_gate dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .special_mode_input(sp), .secured_state_input(se),
      .cmd_launch(cmd_launch), .cmd_code_out(cmd_code_out), .cmd_erase_verify_all(evall),
      .cmd_word(cmd_word), .cmd_word_idx(), .cmd_finish(fin), .res_we(res_we),
      .res_idx(res_idx), .res_data(res_data), .irq(irq));

   always #20 clock = ~clock;

   task close_out;
      $display("Checks %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task wreg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   task rreg(input logic [7:0] a, input logic [15:0] e);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask

   task finish_cmd(input logic [15:0] r);
      @(posedge clock);
      res_we <= 1'b1;
      res_idx <= 3'h1;
      res_data <= r;
      @(posedge clock);
      res_we <= 1'b0;
      fin <= 1'b1;
      @(posedge clock);
      fin <= 1'b0;
      repeat (3) @(posedge clock);
   endtask

   task launch(input logic [7:0] c);
      wreg(`FCLG_OFS_INDEX, 16'h0000);
      wreg(`FCLG_OFS_PARAM, {c, 8'h00});
      wreg(`FCLG_OFS_STATUS, 16'h0001);
      #1 seen = cmd_launch;
      word0 = cmd_word;
      @(posedge clock);
      #1 seen = seen | cmd_launch;
   endtask

   task run(input logic [7:0] c, input logic ex);
      launch(c);
      chk({15'h0000, seen}, {15'h0000, ex});
      if (ex)
      begin
         chk(word0, {c, 8'h00});
         chk({15'h0000, evall}, {15'h0000, c == 8'h01});
         rreg(`FCLG_OFS_STATUS, 16'h0000);
         finish_cmd({8'h5A, c});
         rreg(`FCLG_OFS_STATUS, 16'h0005);
         wreg(`FCLG_OFS_INDEX, 16'h0001);
         rreg(`FCLG_OFS_PARAM, {8'h5A, c});
      end
      else
      begin
         rreg(`FCLG_OFS_STATUS, 16'h0003);
         chk({15'h0000, irq}, 16'h0000);
      end
      wreg(`FCLG_OFS_STATUS, 16'h0006);
   endtask

   initial
   begin
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      rreg(`FCLG_OFS_INDEX, 16'h0000);
      rreg(`FCLG_OFS_STATUS, 16'h0001);
      rreg(`FCLG_OFS_IRQ_MASK, 16'h0000);
      rreg(8'h20, 16'h0000);
      for (int m = 0; m < 4; m++)
      begin
         sp <= m[0];
         se <= m[1];
         repeat (4) @(posedge clock);
         rreg(`FCLG_OFS_MODE, {14'h0000, m[1], m[0]});
         for (int i = 0; i < 19; i++)
            run(rows[i][11:4], rows[i][m]);
      end
      sp <= 1'b0;
      se <= 1'b0;
      repeat (4) @(posedge clock);
      launch(8'h03);
      wreg(`FCLG_OFS_PARAM, 16'h0400);
      wreg(`FCLG_OFS_STATUS, 16'h0001);
      #1 seen = cmd_launch;
      @(posedge clock);
      #1 chk({15'h0000, seen | cmd_launch}, 16'h0000);
      chk({8'h00, cmd_code_out}, 16'h0003);
      finish_cmd(16'h1234);
      rreg(`FCLG_OFS_PARAM, 16'h0300);
      wreg(`FCLG_OFS_STATUS, 16'h0006);
      wreg(`FCLG_OFS_IRQ_MASK, 16'h0006);
      launch(8'h05);
      repeat (2) @(posedge clock);
      #1 chk({15'h0000, irq}, 16'h0001);
      wreg(`FCLG_OFS_STATUS, 16'h0002);
      repeat (2) @(posedge clock);
      #1 chk({15'h0000, irq}, 16'h0000);
      launch(8'h01);
      @(posedge clock);
      rst_n <= 1'b0;
      @(posedge clock);
      rst_n <= 1'b1;
      #1 chk({15'h0000, cmd_launch}, 16'h0000);
      rreg(`FCLG_OFS_STATUS, 16'h0001);
      rreg(`FCLG_OFS_IRQ_MASK, 16'h0000);
      launch(8'h02);
      chk({15'h0000, seen}, 16'h0001);
      finish_cmd(16'h0000);
      rreg(`FCLG_OFS_STATUS, 16'h0005);
      close_out;
   end

   initial
   begin
      repeat (20000) @(posedge clock);
      failures++;
      close_out;
   end
endmodule
`default_nettype wire
